// *** core/epc_arbiter.sv ***
// combinational pick of the most urgent requester by rank key.
// assumes keys are stable for the cycle; equal keys resolve to the lower index.
`timescale 1ns/10ps
`default_nettype none
module epc_arbiter #(
  parameter int N = 50,
  parameter int KW = 5,
  parameter int IW = 6
) (
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0][KW-1:0] key_i,
  output logic found_o,
  output logic [IW-1:0] idx_o,
  output logic [KW-1:0] key_o
);
  always_comb
  begin
    found_o = 1'b0;
    idx_o = '0;
    key_o = '1;
    // ascending scan with strict compare keeps the lower position on ties
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i] && (!found_o || key_i[i] < key_o))
      begin
        found_o = 1'b1;
        idx_o = IW'(i);
        key_o = key_i[i];
      end
    end
  end
endmodule // epc_arbiter
`default_nettype wire

// *** core/epc_pkg.sv ***
// constants, state codes and address windows of the exception priority controller.
// assumes a single 200 MHz core clock and a 32-bit vector table word.
package epc_pkg;
  localparam int EPC_NUM_IRQ = 34;
  localparam int EPC_IRQ_VEC_BASE = 16;
  localparam int EPC_PRI_W = 3;
  localparam int EPC_SUB_W = 2;
  localparam int EPC_KEY_W = 5;
  localparam int EPC_VEC_W = 6;
  localparam int EPC_DATA_W = 32;

  localparam logic [EPC_VEC_W-1:0] EPC_VEC_STACK = 6'h00;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_RESET = 6'h01;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_NMI = 6'h02;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_HARD = 6'h03;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_MEM = 6'h04;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_BUS = 6'h05;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_USAGE = 6'h06;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_SVC = 6'h0B;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_DBGMON = 6'h0C;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_PENDABLE_SERVICE_REQUEST = 6'h0E;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_TICK = 6'h0F;
  localparam logic [EPC_VEC_W-1:0] EPC_VEC_IRQ0 = 6'h10;

  // rank keys: smaller is more urgent; fixed ones sit above every settable level
  localparam logic [EPC_KEY_W-1:0] EPC_KEY_RESET = 5'h00;
  localparam logic [EPC_KEY_W-1:0] EPC_KEY_NMI = 5'h01;
  localparam logic [EPC_KEY_W-1:0] EPC_KEY_HARD = 5'h02;
  localparam logic [EPC_KEY_W-1:0] EPC_KEY_SET_BASE = 5'h08;
  localparam logic [EPC_KEY_W-1:0] EPC_KEY_BASE = 5'h1F;
  localparam logic [EPC_PRI_W-1:0] EPC_PRI_RESET = 3'h0;
  localparam logic [EPC_PRI_W-1:0] EPC_PRI_FULL_MASK = 3'h7;

  typedef enum logic [2:0] {
    EPC_ST_SP = 3'h0,
    EPC_ST_RVEC = 3'h1,
    EPC_ST_RUN = 3'h2,
    EPC_ST_ENTRY = 3'h3,
    EPC_ST_POP = 3'h4
  } epc_state_type;

  // memory regions; flash and sram sizes come from the top module
  localparam logic [31:0] EPC_FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] EPC_FLASH_SPAN = 32'h0004_0000;
  localparam logic [31:0] EPC_SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] EPC_SRAM_SPAN = 32'h0001_0000;
  localparam int EPC_NUM_RANGES = 17;
  localparam logic [31:0] EPC_RANGE_LO [EPC_NUM_RANGES] = '{
    32'h2200_0000, 32'h4000_0000, 32'h4000_4000, 32'h4000_C000, 32'h4002_0000,
    32'h4002_4000, 32'h4002_8000, 32'h4002_C000, 32'h4003_0000, 32'h4003_8000,
    32'h4003_C000, 32'h4004_8000, 32'h400F_C000, 32'h4200_0000, 32'hE000_0000,
    32'hE000_E000, 32'hE004_0000};
  localparam logic [31:0] EPC_RANGE_HI [EPC_NUM_RANGES] = '{
    32'h221F_FFFF, 32'h4000_0FFF, 32'h4000_8FFF, 32'h4000_EFFF, 32'h4002_0FFF,
    32'h4002_6FFF, 32'h4002_8FFF, 32'h4002_CFFF, 32'h4003_2FFF, 32'h4003_8FFF,
    32'h4003_CFFF, 32'h4004_8FFF, 32'h400F_EFFF, 32'h43FF_FFFF, 32'hE000_2FFF,
    32'hE000_EFFF, 32'hE004_0FFF};
endpackage

// *** core/epc_sync.sv ***
// three-stage synchroniser bank for asynchronous request lines.
// assumes inputs may change at any time relative to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module epc_sync #(
  parameter int W = 34
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } epc_sync_state_type;

  epc_sync_state_type s_r;
  epc_sync_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = async_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a change is accepted only when stages two and three agree
    s_nxt.filt = (s_r.s2 & s_r.s3) | (s_r.filt & (s_r.s2 | s_r.s3));
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign level_o = s_r.filt;
endmodule // epc_sync
`default_nettype wire

// *** core/epc_top.sv ***
// exception priority controller: pends, ranks and dispatches exceptions to the core.
// assumes the core answers vector reads, stack pushes and pops with one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - eight levels for seven system handlers and 34 peripheral lines
// - settable level 0 still ranks below reset, nmi and hard fault
// - all settable priority fields reset to level 0
// - equal levels resolve to the lower vector position first
// - reset is vector 1 at -3, drops to base at first instruction
// - nmi is vector 2 at -2, set only by software write
// - hard fault vector 3 at -1 takes faults that cannot activate
// - stack pointer loaded from table entry 0 before execution
// - memory, bus, usage faults on vectors 4, 5, 6 with settable priority
// - bus fault enableable, precise or imprecise reporting
// - supervisor call 11, pendable service 14, system tick 15
// - debug monitor 12 only when enabled, not halting, and urgent enough
// - peripheral requests asynchronous on vectors 16 and up, settable
// - per-line set-enable and priority; handlers use own priority fields
// - priority split in preempt and sub part; only preempt decides nesting
// - entry pushes state and fetches vector together; return restores
// - pending exception at return is entered without pop and push
// - reserved space or absent flash or sram access gives a bus fault
// - peripheral line n maps to vector n plus 16
module epc_top
  import epc_pkg::*;
#(
  parameter int NUM_IRQ = epc_pkg::EPC_NUM_IRQ,
  parameter logic [31:0] FLASH_BYTES = epc_pkg::EPC_FLASH_SPAN,
  parameter logic [31:0] SRAM_BYTES = epc_pkg::EPC_SRAM_SPAN
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [NUM_IRQ-1:0] irq_i,
  input wire logic [NUM_IRQ-1:0] irq_en_set_i,
  input wire logic [NUM_IRQ-1:0] irq_en_clr_i,
  input wire logic [NUM_IRQ-1:0] irq_pend_clr_i,
  input wire logic pri_wr_i,
  input wire logic [epc_pkg::EPC_VEC_W-1:0] pri_wr_vec_i,
  input wire logic [epc_pkg::EPC_PRI_W-1:0] pri_wr_level_i,
  input wire logic [epc_pkg::EPC_SUB_W-1:0] sub_bits_i,
  input wire logic nmi_set_i,
  input wire logic pendable_service_request_set_i,
  input wire logic tick_i,
  input wire logic svc_i,
  input wire logic fault_mem_i,
  input wire logic fault_usage_i,
  input wire logic fault_bus_precise_i,
  input wire logic fault_bus_imprecise_i,
  input wire logic bus_fault_en_i,
  input wire logic dbg_mon_req_i,
  input wire logic dbg_mon_en_i,
  input wire logic halting_i,
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic first_instr_i,
  input wire logic exc_return_i,
  input wire logic vtab_ack_i,
  input wire logic [epc_pkg::EPC_DATA_W-1:0] vtab_data_i,
  input wire logic push_done_i,
  input wire logic pop_done_i,
  output logic vtab_rd_o,
  output logic [epc_pkg::EPC_VEC_W-1:0] vtab_idx_o,
  output logic push_req_o,
  output logic pop_req_o,
  output logic [epc_pkg::EPC_DATA_W-1:0] sp_o,
  output logic sp_load_o,
  output logic [epc_pkg::EPC_DATA_W-1:0] pc_o,
  output logic pc_load_o,
  output logic handler_mode_o,
  output logic tail_chain_o,
  output logic [epc_pkg::EPC_VEC_W-1:0] active_vec_o,
  output logic acc_fault_o,
  output logic [epc_pkg::EPC_IRQ_VEC_BASE+NUM_IRQ-1:0] pend_o,
  output logic [epc_pkg::EPC_IRQ_VEC_BASE+NUM_IRQ-1:0] active_o
);
  import epc_pkg::*;

  localparam int NV = EPC_IRQ_VEC_BASE + NUM_IRQ;

  typedef struct packed {
    epc_state_type state;
    logic [NV-1:0][EPC_PRI_W-1:0] pri;
    logic [NUM_IRQ-1:0] irq_en;
    logic [NV-1:0] pend;
    logic [NV-1:0] act;
    logic reset_act;
    logic pushed;
    logic fetched;
    logic tail;
    logic sp_load;
    logic pc_load;
    logic handler_mode;
    logic acc_fault;
    logic [EPC_VEC_W-1:0] cur_vec;
    logic [EPC_VEC_W-1:0] vtab_idx;
    logic [EPC_DATA_W-1:0] sp;
    logic [EPC_DATA_W-1:0] pc;
  } epc_core_state_type;

  // every priority field starts at level 0
  localparam epc_core_state_type EPC_RESET_VAL = '{
    state: EPC_ST_SP, reset_act: 1'b1, default: '0};

  epc_core_state_type s_r;
  epc_core_state_type s_nxt;

  logic [NUM_IRQ-1:0] irq_level;
  logic [NV-1:0][EPC_KEY_W-1:0] fkey;
  logic [NV-1:0][EPC_KEY_W-1:0] pkey;
  logic [NV-1:0] pend_elig;
  logic [NV-1:0] act_view;
  logic win_found;
  logic [EPC_VEC_W-1:0] win_idx;
  logic [EPC_KEY_W-1:0] win_key;
  logic act_found;
  logic [EPC_VEC_W-1:0] act_idx;
  logic [EPC_KEY_W-1:0] act_key;
  logic [EPC_KEY_W-1:0] exec_key;
  logic returning;

  // fixed ranks sit above the settable range, so level 0 is fourth
  function automatic logic [EPC_KEY_W-1:0] key_of(input logic [EPC_VEC_W-1:0] v,
    input logic [EPC_PRI_W-1:0] p, input logic [EPC_SUB_W-1:0] sb, input logic pre);
    logic [EPC_PRI_W-1:0] m;
    m = pre ? EPC_PRI_FULL_MASK << sb : EPC_PRI_FULL_MASK;
    if (v == EPC_VEC_RESET)
      key_of = EPC_KEY_RESET;
    else if (v == EPC_VEC_NMI)
      key_of = EPC_KEY_NMI;
    else if (v == EPC_VEC_HARD)
      key_of = EPC_KEY_HARD;
    else
      key_of = EPC_KEY_SET_BASE + {{(EPC_KEY_W-EPC_PRI_W){1'b0}}, p & m};
  endfunction

  function automatic logic settable(input logic [EPC_VEC_W-1:0] v);
    settable = (v == EPC_VEC_MEM) || (v == EPC_VEC_BUS) || (v == EPC_VEC_USAGE)
      || (v == EPC_VEC_SVC) || (v == EPC_VEC_DBGMON) || (v == EPC_VEC_PENDABLE_SERVICE_REQUEST)
      || (v == EPC_VEC_TICK) || (v >= EPC_VEC_IRQ0 && v < EPC_VEC_W'(NV));
  endfunction

  function automatic logic addr_fault(input logic [31:0] a);
    logic hit;
    hit = (a - EPC_FLASH_BASE) < FLASH_BYTES;
    hit = hit || (a >= EPC_SRAM_BASE && (a - EPC_SRAM_BASE) < SRAM_BYTES);
    for (int k = 0; k < EPC_NUM_RANGES; k++)
      hit = hit || (a >= EPC_RANGE_LO[k] && a <= EPC_RANGE_HI[k]);
    addr_fault = !hit;
  endfunction

  // peripheral lines are asynchronous to the core clock
  epc_sync #(
    .W(NUM_IRQ)
  ) u_irq_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(irq_i),
    .level_o(irq_level)
  );

  always_comb
  begin
    for (int i = 0; i < NV; i++)
    begin
      fkey[i] = key_of(EPC_VEC_W'(i), s_r.pri[i], sub_bits_i, 1'b0);
      pkey[i] = key_of(EPC_VEC_W'(i), s_r.pri[i], sub_bits_i, 1'b1);
    end
  end

  // a returning handler no longer holds the execution level
  assign returning = (s_r.state == EPC_ST_RUN) && s_r.handler_mode && exc_return_i;
  always_comb
  begin
    act_view = s_r.act;
    if (returning)
      act_view[s_r.cur_vec] = 1'b0;
    pend_elig = s_r.pend;
    if (!bus_fault_en_i)
      pend_elig[EPC_VEC_BUS] = 1'b0;
  end

  // full key ranks pending sources; lower position wins ties
  epc_arbiter #(
    .N(NV),
    .KW(EPC_KEY_W),
    .IW(EPC_VEC_W)
  ) u_pend_arb (
    .req_i(pend_elig),
    .key_i(fkey),
    .found_o(win_found),
    .idx_o(win_idx),
    .key_o(win_key)
  );

  // only the preempt part sets the current execution level
  epc_arbiter #(
    .N(NV),
    .KW(EPC_KEY_W),
    .IW(EPC_VEC_W)
  ) u_act_arb (
    .req_i(act_view),
    .key_i(pkey),
    .found_o(act_found),
    .idx_o(act_idx),
    .key_o(act_key)
  );

  assign exec_key = s_r.reset_act ? EPC_KEY_RESET : (act_found ? act_key : EPC_KEY_BASE);

  always_comb
  begin
    logic [NV-1:0] ev_set;
    logic [NV-1:0] ev_clr;
    logic bus_ev;
    logic take;
    ev_set = '0;
    ev_clr = '0;
    bus_ev = 1'b0;
    take = 1'b0;
    s_nxt = s_r;
    s_nxt.sp_load = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.acc_fault = 1'b0;

    if (pri_wr_i && settable(pri_wr_vec_i))
      s_nxt.pri[pri_wr_vec_i] = pri_wr_level_i;
    s_nxt.irq_en = (s_r.irq_en | irq_en_set_i) & ~irq_en_clr_i;
    if (first_instr_i)
      s_nxt.reset_act = 1'b0;

    for (int i = 0; i < NUM_IRQ; i++)
    begin
      ev_set[EPC_IRQ_VEC_BASE + i] = irq_level[i] & s_r.irq_en[i];
      ev_clr[EPC_IRQ_VEC_BASE + i] = irq_pend_clr_i[i];
    end
    ev_set[EPC_VEC_NMI] = nmi_set_i;
    ev_set[EPC_VEC_PENDABLE_SERVICE_REQUEST] = pendable_service_request_set_i;
    ev_set[EPC_VEC_TICK] = tick_i;
    ev_set[EPC_VEC_SVC] = svc_i;
    if (dbg_mon_req_i && dbg_mon_en_i && !halting_i && pkey[EPC_VEC_DBGMON] < exec_key)
      ev_set[EPC_VEC_DBGMON] = 1'b1;

    // synchronous faults that cannot activate escalate to hard fault
    if (fault_mem_i)
      ev_set[(pkey[EPC_VEC_MEM] < exec_key) ? EPC_VEC_MEM : EPC_VEC_HARD] = 1'b1;
    if (fault_usage_i)
      ev_set[(pkey[EPC_VEC_USAGE] < exec_key) ? EPC_VEC_USAGE : EPC_VEC_HARD] = 1'b1;
    if (acc_valid_i && addr_fault(acc_addr_i))
    begin
      s_nxt.acc_fault = 1'b1;
      bus_ev = 1'b1;
    end
    if (fault_bus_precise_i || bus_ev)
      take = bus_fault_en_i && pkey[EPC_VEC_BUS] < exec_key;
    // an imprecise fault may wait for its turn while enabled
    if (fault_bus_imprecise_i && bus_fault_en_i)
      ev_set[EPC_VEC_BUS] = 1'b1;
    if (fault_bus_precise_i || bus_ev || (fault_bus_imprecise_i && !bus_fault_en_i))
      ev_set[take ? EPC_VEC_BUS : EPC_VEC_HARD] = 1'b1;

    unique case (s_r.state)
      EPC_ST_SP:
      begin
        s_nxt.vtab_idx = EPC_VEC_STACK;
        if (vtab_ack_i)
        begin
          s_nxt.sp = vtab_data_i;
          s_nxt.sp_load = 1'b1;
          s_nxt.vtab_idx = EPC_VEC_RESET;
          s_nxt.state = EPC_ST_RVEC;
        end
      end
      EPC_ST_RVEC:
      begin
        if (vtab_ack_i)
        begin
          s_nxt.pc = vtab_data_i;
          s_nxt.pc_load = 1'b1;
          s_nxt.state = EPC_ST_RUN;
        end
      end
      EPC_ST_RUN:
      begin
        if (returning)
          s_nxt.act[s_r.cur_vec] = 1'b0;
        if (win_found && pkey[win_idx] < exec_key)
        begin
          // at return this skips the pop and the next push
          s_nxt.tail = returning;
          s_nxt.state = EPC_ST_ENTRY;
          s_nxt.cur_vec = win_idx;
          s_nxt.vtab_idx = win_idx;
          s_nxt.act[win_idx] = 1'b1;
          s_nxt.pushed = 1'b0;
          s_nxt.fetched = 1'b0;
          ev_clr[win_idx] = 1'b1;
        end
        else if (returning)
          s_nxt.state = EPC_ST_POP;
      end
      EPC_ST_ENTRY:
      begin
        if (push_done_i)
          s_nxt.pushed = 1'b1;
        if (vtab_ack_i)
        begin
          s_nxt.fetched = 1'b1;
          s_nxt.pc = vtab_data_i;
        end
        if ((s_r.pushed || s_r.tail || push_done_i) && (s_r.fetched || vtab_ack_i))
        begin
          s_nxt.pc_load = 1'b1;
          s_nxt.handler_mode = 1'b1;
          s_nxt.tail = 1'b0;
          s_nxt.state = EPC_ST_RUN;
        end
      end
      EPC_ST_POP:
      begin
        if (pop_done_i)
        begin
          s_nxt.handler_mode = act_found;
          s_nxt.cur_vec = act_found ? act_idx : EPC_VEC_STACK;
          s_nxt.state = EPC_ST_RUN;
        end
      end
      default:
        s_nxt.state = EPC_ST_SP;
    endcase

    // a new request in the cycle of its clear is kept
    s_nxt.pend = ev_set | (s_r.pend & ~ev_clr);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      s_r <= EPC_RESET_VAL;
    else
      s_r <= s_nxt;
  end

  // vector read and stack push run side by side during entry
  assign vtab_rd_o = (s_r.state == EPC_ST_SP) || (s_r.state == EPC_ST_RVEC)
    || ((s_r.state == EPC_ST_ENTRY) && !s_r.fetched);
  assign push_req_o = (s_r.state == EPC_ST_ENTRY) && !s_r.pushed && !s_r.tail;
  assign pop_req_o = (s_r.state == EPC_ST_POP);
  assign vtab_idx_o = s_r.vtab_idx;
  assign sp_o = s_r.sp;
  assign sp_load_o = s_r.sp_load;
  assign pc_o = s_r.pc;
  assign pc_load_o = s_r.pc_load;
  assign handler_mode_o = s_r.handler_mode;
  assign tail_chain_o = s_r.tail;
  assign active_vec_o = s_r.cur_vec;
  assign acc_fault_o = s_r.acc_fault;
  assign pend_o = s_r.pend;
  assign active_o = s_r.act;
endmodule // epc_top
`default_nettype wire

// *** testbench/epc_core_model.sv ***
// behavioural core side: answers vector reads, stack pushes and pops.
// assumes each request stands until its strobe; stalls are random.
`timescale 1ns/10ps
`default_nettype none
module epc_core_model #(
  parameter logic [31:0] VTAB_TAG = 32'h5A00_0000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic vtab_rd_i,
  input wire logic [epc_pkg::EPC_VEC_W-1:0] vtab_idx_i,
  input wire logic push_req_i,
  input wire logic pop_req_i,
  output logic vtab_ack_o,
  output logic [31:0] vtab_data_o,
  output logic push_done_o,
  output logic pop_done_o
);
  logic [2:0] req;
  logic [2:0] ans;
  int unsigned dly [3];
  assign req = {pop_req_i, push_req_i, vtab_rd_i};
  assign vtab_ack_o = ans[0];
  assign push_done_o = ans[1];
  assign pop_done_o = ans[2];
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      ans <= '0;
      dly <= '{default: 0};
      vtab_data_o <= '0;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        ans[k] <= 1'b0;
        if (req[k] && !ans[k] && dly[k] == 0)
        begin
          ans[k] <= 1'b1;
          dly[k] <= $urandom_range(3, 0);
        end
        else if (req[k] && !ans[k])
          dly[k] <= dly[k] - 1;
      end
      if (req[0] && !ans[0] && dly[0] == 0)
        vtab_data_o <= VTAB_TAG | 32'(vtab_idx_i);
      else if (ans[0])
        vtab_data_o <= ~vtab_data_o; // poison stale data
    end
endmodule // epc_core_model
`default_nettype wire

// *** testbench/epc_monitor.sv ***
// assertions on the ports of the exception priority controller top.
// assumes one clock domain and the strobe timing of the core handshakes.
`timescale 1ns/10ps
`default_nettype none
module epc_monitor #(
  parameter int NUM_IRQ = 34
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [NUM_IRQ-1:0] irq_i,
  input wire logic nmi_set_i,
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic first_instr_i,
  input wire logic vtab_ack_i,
  input wire logic [epc_pkg::EPC_DATA_W-1:0] vtab_data_i,
  input wire logic push_done_i,
  input wire logic vtab_rd_o,
  input wire logic [epc_pkg::EPC_VEC_W-1:0] vtab_idx_o,
  input wire logic push_req_o,
  input wire logic pop_req_o,
  input wire logic [epc_pkg::EPC_DATA_W-1:0] sp_o,
  input wire logic sp_load_o,
  input wire logic pc_load_o,
  input wire logic handler_mode_o,
  input wire logic tail_chain_o,
  input wire logic acc_fault_o,
  input wire logic [epc_pkg::EPC_IRQ_VEC_BASE+NUM_IRQ-1:0] pend_o
);
  import epc_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // high from reset until the first instruction retires
  logic boot_r;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      boot_r <= 1'b1;
    else if (first_instr_i)
      boot_r <= 1'b0;
  a_sp_from_table: assert property (sp_load_o |-> $past(vtab_ack_i) &&
    $past(vtab_idx_o) == EPC_VEC_STACK && sp_o == $past(vtab_data_i)) else $error("stack load");
  a_pc_after_answer: assert property (pc_load_o |-> $past(vtab_ack_i) ||
    $past(push_done_i)) else $error("pc load without answer");
  a_save_with_fetch: assert property ($rose(push_req_o) |-> vtab_rd_o ##[1:40] pc_load_o)
    else $error("push without fetch");
  a_tail_no_stack: assert property (tail_chain_o |-> !push_req_o && !pop_req_o)
    else $error("stack traffic in tail chain");
  a_reset_level_holds: assert property (boot_r |-> !push_req_o && !handler_mode_o)
    else $error("entry before first instruction");
  a_irq_sync_path: assert property ($rose(pend_o[EPC_IRQ_VEC_BASE]) |->
    $past(irq_i[0], 3) || $past(irq_i[0], 4) || $past(irq_i[0], 5)) else $error("line 0 pend");
  a_nmi_by_write: assert property ($rose(pend_o[EPC_VEC_NMI]) |-> $past(nmi_set_i))
    else $error("nmi pended without write");
  a_fault_reserved: assert property (acc_valid_i && acc_addr_i[31:28] == 4'hF |=> acc_fault_o)
    else $error("reserved access not faulted");
  a_fault_cause: assert property (acc_fault_o |-> $past(acc_valid_i))
    else $error("fault without access");
  a_mode_entry: assert property ($rose(handler_mode_o) |-> pc_load_o)
    else $error("mode without pc load");
  c_tail: cover property (tail_chain_o);
  c_nest: cover property (push_req_o && handler_mode_o);
  c_fault: cover property (acc_fault_o);
endmodule // epc_monitor
bind epc_top epc_monitor #(.NUM_IRQ(NUM_IRQ)) mon_u (.clk_sys_i, .rst_i, .irq_i, .nmi_set_i,
  .acc_valid_i, .acc_addr_i, .first_instr_i, .vtab_ack_i, .vtab_data_i, .push_done_i,
  .vtab_rd_o, .vtab_idx_o, .push_req_o, .pop_req_o, .sp_o, .sp_load_o, .pc_load_o,
  .handler_mode_o, .tail_chain_o, .acc_fault_o, .pend_o);
`default_nettype wire

// *** testbench/exception_priority_controller_tb.sv ***
// self-checking bench for the exception priority controller top.
// assumes the core model answers every vector read and stack request.
`timescale 1ns/10ps
`default_nettype none
module exception_priority_controller_tb;
  import epc_pkg::*;
  localparam logic [31:0] TAG = 32'h5A00_0000;
  localparam logic [31:0] FLASH_B = 32'h0002_0000;
  localparam logic [31:0] SRAM_B = 32'h0000_8000;
  // strobes: nmi pendable_service_request tick svc mem usage dbg bus_precise bus_imprecise
  localparam logic [5:0] EV_VEC [9] = '{6'h02, 6'h0E, 6'h0F, 6'h0B, 6'h04, 6'h06, 6'h0C, 6'h05, 6'h05};
  localparam logic [31:0] FIX [5] = '{32'h0000_0100, 32'h0003_0000, 32'h2000_9000,
    32'h4000_4000, 32'hF000_0000};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [33:0] irq_i = '0;
  logic [33:0] en_set = '0;
  logic [33:0] en_clr = '0;
  logic [33:0] pend_clr = '0;
  logic pri_wr_i = 1'b0;
  logic [EPC_VEC_W-1:0] pri_vec = '0;
  logic [EPC_PRI_W-1:0] pri_lvl = '0;
  logic [EPC_SUB_W-1:0] sub_bits_i = '0;
  logic [10:0] ev = '0;
  logic bus_fault_en_i = 1'b1;
  logic acc_valid_i = 1'b0;
  logic [31:0] acc_addr_i = '0;
  logic vtab_ack_i, push_done_i, pop_done_i, vtab_rd_o, push_req_o, pop_req_o;
  logic sp_load_o, pc_load_o, handler_mode_o, tail_chain_o, acc_fault_o;
  logic [31:0] vtab_data_i, sp_o, pc_o;
  logic [EPC_VEC_W-1:0] vtab_idx_o, av;
  logic [49:0] pend_o;
  logic [EPC_VEC_W-1:0] exp_q [$];
  logic exp_f [$];
  logic acc_chk = 1'b0;
  logic [2:0] lo, hi;
  int err_total = 0;
  int check_count = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  epc_top #(.FLASH_BYTES(FLASH_B), .SRAM_BYTES(SRAM_B)) dut_u (.clk_sys_i, .rst_i, .irq_i,
    .irq_en_set_i(en_set), .irq_en_clr_i(en_clr), .irq_pend_clr_i(pend_clr), .pri_wr_i,
    .pri_wr_vec_i(pri_vec), .pri_wr_level_i(pri_lvl), .sub_bits_i, .nmi_set_i(ev[0]),
    .pendable_service_request_set_i(ev[1]), .tick_i(ev[2]), .svc_i(ev[3]), .fault_mem_i(ev[4]),
    .fault_usage_i(ev[5]), .dbg_mon_req_i(ev[6]), .fault_bus_precise_i(ev[7]),
    .fault_bus_imprecise_i(ev[8]), .first_instr_i(ev[9]), .exc_return_i(ev[10]),
    .bus_fault_en_i, .dbg_mon_en_i(1'b1), .halting_i(1'b0), .acc_valid_i, .acc_addr_i,
    .vtab_ack_i, .vtab_data_i, .push_done_i, .pop_done_i, .vtab_rd_o, .vtab_idx_o, .push_req_o,
    .pop_req_o, .sp_o, .sp_load_o, .pc_o, .pc_load_o, .handler_mode_o, .tail_chain_o,
    .active_vec_o(av), .acc_fault_o, .pend_o, .active_o());
  epc_core_model #(.VTAB_TAG(TAG)) core_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .vtab_rd_i(vtab_rd_o), .vtab_idx_i(vtab_idx_o), .push_req_i(push_req_o),
    .pop_req_i(pop_req_o), .vtab_ack_o(vtab_ack_i), .vtab_data_o(vtab_data_i),
    .push_done_o(push_done_i), .pop_done_o(pop_done_i));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_for(input logic hm, input int left);
    for (int n = 0; n < 400 && (exp_q.size() > left || handler_mode_o !== hm); n++)
      @(negedge clk_sys_i);
    if (exp_q.size() > left || handler_mode_o !== hm)
    begin
      err_total++;
      $display("[FAIL] entry wait expected done seen timeout");
      results();
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    ev[i] <= 1'b1;
    @(posedge clk_sys_i);
    ev[i] <= 1'b0;
  endtask
  function automatic logic is_fault(input logic [31:0] a);
    logic ok;
    ok = a < FLASH_B || (a >= EPC_SRAM_BASE && a < EPC_SRAM_BASE + SRAM_B);
    for (int k = 0; k < EPC_NUM_RANGES; k++)
      if (a >= EPC_RANGE_LO[k] && a <= EPC_RANGE_HI[k])
        ok = 1'b1;
    return !ok;
  endfunction
  task automatic access(input logic [31:0] a);
    @(posedge clk_sys_i);
    exp_f.push_back(is_fault(a));
    if (is_fault(a))
      exp_q.push_back(bus_fault_en_i ? EPC_VEC_BUS : EPC_VEC_HARD);
    acc_valid_i <= 1'b1;
    acc_addr_i <= a;
    @(posedge clk_sys_i);
    acc_valid_i <= 1'b0;
    if (is_fault(a))
    begin
      wait_for(1'b1, 0);
      pulse(10);
    end
    wait_for(1'b0, 0);
  endtask
  // results are judged where they appear, in arrival order
  always @(negedge clk_sys_i)
  begin
    if (pc_load_o === 1'b1 && handler_mode_o === 1'b1 && exp_q.size() > 0)
      check("active vector", 32'(exp_q[0]), 32'(av));
    if (sp_load_o === 1'b1)
      check("stack pointer", TAG, sp_o);
    if (pc_load_o === 1'b1 && exp_q.size() == 0)
      check("unexpected entry", 32'h0, pc_o);
    else if (pc_load_o === 1'b1)
      check("handler address", TAG | 32'(exp_q.pop_front()), pc_o);
    if (acc_chk)
      check("access fault", 32'(exp_f.pop_front()), 32'(acc_fault_o));
    acc_chk = acc_valid_i;
  end
  initial
  begin
    void'($urandom(32'h2ED5BF9B));
    exp_q.push_back(EPC_VEC_RESET);
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wait_for(1'b0, 0);
    exp_q.push_back(EPC_VEC_NMI);
    pulse(0);
    repeat (10) @(posedge clk_sys_i);
    check("held at reset level", 32'h1, 32'(exp_q.size()));
    pulse(9);
    for (int i = 0; i < 9; i++)
    begin
      if (i > 0)
        exp_q.push_back(EV_VEC[i]);
      if (i > 0)
        pulse(i);
      wait_for(1'b1, 0);
      pulse(10);
      wait_for(1'b0, 0);
    end
    foreach (FIX[k])
      access(FIX[k]);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk_sys_i);
      bus_fault_en_i <= 1'($urandom);
      access($urandom);
    end
    @(posedge clk_sys_i);
    en_set <= 34'h0_0000_000F;
    exp_q.push_back(EPC_VEC_IRQ0);
    exp_q.push_back(EPC_VEC_IRQ0 + 6'h01);
    irq_i[1:0] <= 2'h3;
    wait_for(1'b1, 1);
    @(posedge clk_sys_i);
    irq_i[1:0] <= 2'h0;
    en_set <= '0;
    repeat (6) @(posedge clk_sys_i);
    pend_clr <= 34'h1;
    @(posedge clk_sys_i);
    pend_clr <= '0;
    pulse(10);
    wait_for(1'b1, 0);
    pulse(10);
    wait_for(1'b0, 0);
    for (int s = 0; s < 2; s++)
    begin
      hi = 3'($urandom_range(2, 0));
      lo = 3'($urandom_range(7, 4));
      @(posedge clk_sys_i);
      pri_wr_i <= 1'b1;
      pri_vec <= EPC_VEC_IRQ0 + 6'h02;
      pri_lvl <= lo;
      @(posedge clk_sys_i);
      pri_vec <= EPC_VEC_IRQ0 + 6'h03;
      pri_lvl <= hi;
      sub_bits_i <= s ? 2'h3 : 2'h0;
      @(posedge clk_sys_i);
      pri_wr_i <= 1'b0;
      exp_q.push_back(EPC_VEC_IRQ0 + 6'h02);
      exp_q.push_back(EPC_VEC_IRQ0 + 6'h03);
      irq_i[2] <= 1'b1;
      wait_for(1'b1, 1);
      @(posedge clk_sys_i);
      irq_i[3:2] <= 2'h2;
      repeat (20) @(posedge clk_sys_i);
      irq_i[3] <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      pend_clr <= s ? 34'h4 : 34'hC;
      @(posedge clk_sys_i);
      pend_clr <= '0;
      check("preempt by level", 32'(s), 32'(exp_q.size()));
      pulse(10);
      wait_for(1'b1, 0);
      repeat (12) @(posedge clk_sys_i);
      pulse(10);
      wait_for(1'b0, 0);
    end
    @(posedge clk_sys_i);
    en_clr <= 34'h1;
    @(posedge clk_sys_i);
    en_clr <= '0;
    irq_i[0] <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("disabled line pending", 32'h0, 32'(pend_o[EPC_IRQ_VEC_BASE]));
    results();
  end
endmodule // exception_priority_controller_tb
`default_nettype wire
